// File: fwp_checker.sv
// fwp_checker: port-level checks on the fault/warning pin logic
// assumes a bind from the bench top and a short ramp (about 20 cycles)
`timescale 1ns/1ps
module fwp_checker
	import fwp_pkg::*;
#(
	parameter int CHANNELS    = 4,
	parameter int RAMP_CYCLES = 20
) (
	// clock, reset and event inputs
	input wire logic                        clk_sys,
	input wire logic                        rst_n,
	input wire fwp_pkg::fwp_fault_type      fault_in,
	input wire fwp_pkg::fwp_warn_type       warn_in,
	input wire fwp_pkg::fwp_fault_mask_type fault_mask,
	input wire fwp_pkg::fwp_warn_mask_type  warn_mask,
	input wire logic                        clear_latch_wr,
	input wire logic                        mute_n,
	input wire logic                        standby_n,
	// outputs under watch
	input wire logic                        alarm_oe_n,
	input wire logic                        caution_oe_n,
	input wire fwp_pkg::fwp_status_type     status,
	input wire logic                        clear_latch_bit,
	input wire fwp_pkg::fwp_state_type      op_state,
	input wire logic                        outputs_floating,
	input wire logic                        osc_run,
	input wire logic                        mute_all,
	input wire logic                        ramp_active
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	clock_alarm_a: assert property (fault_in.clock_error && !fault_mask.clock |=> !alarm_oe_n)
		else $error("alarm not driven by clock error");
	high_status_a: assert property (fault_in.supply_high_alarm |=> status.supply_high_alarm)
		else $error("supply high not recorded");
	alarm_hold_a: assert property (!alarm_oe_n && !clear_latch_wr |=> !alarm_oe_n)
		else $error("alarm released without clear");
	status_hold_a: assert property (status.clock_error && !clear_latch_wr |=> $stable(status.clock_error))
		else $error("fault status dropped without clear");
	clear_release_a: assert property (clear_latch_wr && fault_in == '0 |=> alarm_oe_n && clear_latch_bit ##1 !clear_latch_bit)
		else $error("latch release misbehaved");
	quiet_alarm_a: assert property (fault_in == '0 && alarm_oe_n |=> alarm_oe_n)
		else $error("alarm raised with no fault");
	otw_caution_a: assert property ((|warn_in.chan_overtemp_warning) && !warn_mask.overtemp |=> !caution_oe_n)
		else $error("channel overtemp warning not on caution");
	mute_all_a: assert property (!mute_n |=> mute_all)
		else $error("mute input ignored");
	ramp_down_a: assert property ($fell(standby_n) && op_state inside {ST_MUTE, ST_PLAY}
		|=> ramp_active ##[1:30] op_state == ST_STANDBY)
		else $error("standby ramp not finished in time");
	standby_float_a: assert property (op_state == ST_STANDBY |=> outputs_floating && !osc_run)
		else $error("standby state drives outputs");
endmodule // fwp_checker

// File: fwp_host.sv
// fwp_host: host controller model driving the mute, standby and play pins
// assumes the bench sets want_play, want_mute and want_off levels
`timescale 1ns/1ps
module fwp_host #(
	parameter int HOLD = 30
) (
	// clock and commands
	input  wire logic clk_sys,
	input  wire logic want_play,
	input  wire logic want_off,
	input  wire logic want_mute,
	// pins toward the device
	output logic      mute_n,
	output logic      standby_n,
	output logic      play_request,
	output logic      power_good
);
	int low_cnt = 0;
	initial mute_n = 1'b0;
	initial standby_n = 1'b0;
	initial play_request = 1'b0;
	initial power_good = 1'b1;
	// commands taken at the edge, pins move 1 ns later, like firmware would
	always @(posedge clk_sys) begin
		standby_n <= #1 !want_off;
		mute_n <= #1 !want_mute;
		play_request <= #1 want_play;
		low_cnt <= standby_n ? 0 : low_cnt + 1;
		power_good <= #1 !(want_off && low_cnt >= HOLD); // supplies drop only after a long standby
	end
endmodule // fwp_host

// File: fwp_pkg.sv
// fwp_pkg: shared constants, types and states for the fault/warning pin logic
// assumes a 250 MHz system clock; register fields arrive as plain ports
package fwp_pkg;
	localparam int CLK_MHZ               = 250;
	localparam int CHANNELS              = 4;
	localparam int CLIP_WIN_W            = 8;
	localparam logic [7:0] CLIP_WIN_RESET = 8'h14;   // 20 pwm clocks
	localparam int CLR_REG_ADDR          = 32'h21;    // latch-release register
	localparam int CLR_BIT_POS           = 7;
	localparam int OTW_REG_ADDR          = 32'h01;    // warning threshold register
	localparam int OTW_LVL_LSB           = 5;
	localparam int OTW_LVL_MSB           = 6;
	localparam int RAMP_US               = 5000;      // outputs ramp down within 5 ms
	localparam int RAMP_CYCLES           = RAMP_US * CLK_MHZ;
	localparam int PWR_OFF_HOLD_US       = 15000;     // host keeps standby low before power removal
	localparam logic [1:0] OTW_LVL_RESET = 2'h0;

	// raw protection events, one cycle snapshot
	typedef struct packed {
		logic [CHANNELS-1:0] chan_fault;       // overcurrent or dc offset per channel
		logic                overtemp_shutdown;
		logic                supply_high_alarm;
		logic                supply_low_alarm;
		logic                clock_error;
	} fwp_fault_type;

	typedef struct packed {
		logic [CHANNELS-1:0] chan_full_mod;    // channel at 100% duty this pwm clock
		logic                overtemp_warning;
		logic [CHANNELS-1:0] chan_overtemp_warning;
		logic [CHANNELS-1:0] current_limit_warning;
	} fwp_warn_type;

	// mask bits for the alarm output, one per category
	typedef struct packed {
		logic chan;
		logic thermal;
		logic supply;
		logic clock;
	} fwp_fault_mask_type;

	typedef struct packed {
		logic clip;
		logic overtemp;
		logic current_limit;
	} fwp_warn_mask_type;

	// sticky status seen by software
	typedef struct packed {
		logic [CHANNELS-1:0] chan_fault;
		logic                overtemp_shutdown;
		logic                supply_high_alarm;
		logic                supply_low_alarm;
		logic                clock_error;
		logic                clip;
		logic                overtemp_warning;
		logic [CHANNELS-1:0] current_limit_warning;
		logic                por;
	} fwp_status_type;

	typedef enum logic [3:0] {
		ST_STANDBY  = 4'h1,
		ST_FLOATING = 4'h2,
		ST_MUTE     = 4'h4,
		ST_PLAY     = 4'h8
	} fwp_state_type;
endpackage

// File: fwp_top.sv
// fwp_top: latches protection events onto active-low alarm and caution outputs,
// tracks the operating state from mute and standby inputs
// assumes all inputs synchronous to clk_sys; register fields are plain ports
// the 5 ms ramp is RAMP_CYCLES clocks; benches shorten it through the parameter
`timescale 1ns/1ps
// Function
// RL1: supply over threshold asserts alarm output and records status bit.
// RL2: channel, thermal shutdown, supply or clock faults drive alarm low.
// RL3: alarm stays latched until host writes latch-release bit.
// RL4: fault status bits stay set until latch-release write.
// RL5: fault masks gate only the alarm output, not status or protection.
// RL6: all fault masks are clear after reset.
// RL7: clipping, overtemp warning, current limit or power-on reset drive caution low.
// RL8: clip flagged after programmable consecutive full-modulation pwm clocks, default 20.
// RL9: latching clip status stays set until latch-release write.
// RL10: global or any channel temperature warning reports overtemp warning.
// RL11: two-bit warning threshold field selects overtemp warning level.
// RL12: clip, overtemp and current-limit masks gate caution only; clear after reset.
// RL13: caution output latches until latch-release write.
// RL14: low mute input mutes all channels; high lets them unmute.
// RL15: standby low shuts down, ramping outputs down within 5 ms.
// RL16: four states standby, floating, mute, play; register access always live.
// RL17: host holds standby low 15 ms before removing any supply; the fwp_host model holds it HOLD clocks, 30 by default.
// RL18: power-on reset sets por warning status and asserts caution.
// RL19: non-latching clip indication follows full modulation directly.
// RL20: current limit reports only as warning, never as fault.
// RL21: latch-release clears all status and both latches, then self-clears.
// RL22: sources still active during release set their bits again next cycle.
module fwp_top #(
	parameter int CHANNELS    = fwp_pkg::CHANNELS,
	parameter int RAMP_CYCLES = fwp_pkg::RAMP_CYCLES
) (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// protection event sources
	input  wire fwp_pkg::fwp_fault_type      fault_in,
	input  wire fwp_pkg::fwp_warn_type       warn_in,
	input  wire logic                        pwm_tick,
	// register fields
	input  wire fwp_pkg::fwp_fault_mask_type fault_mask,
	input  wire fwp_pkg::fwp_warn_mask_type  warn_mask,
	input  wire logic [7:0]                  clip_window,
	input  wire logic                        clip_latching,
	input  wire logic [1:0]                  otw_level_sel,
	input  wire logic                        clear_latch_wr,
	input  wire logic                        play_request,
	// host control pins
	input  wire logic                        mute_n,
	input  wire logic                        standby_n,
	// open-drain outputs, enable low while pulling the pin low
	output logic                             alarm_out,
	output logic                             alarm_oe_n,
	output logic                             caution_out,
	output logic                             caution_oe_n,
	// status and state
	output fwp_pkg::fwp_status_type          status,
	output logic [1:0]                       otw_level,
	output logic                             clear_latch_bit,
	output fwp_pkg::fwp_state_type           op_state,
	output logic                             outputs_floating,
	output logic                             osc_run,
	output logic                             mute_all,
	output logic                             ramp_active
);
	import fwp_pkg::*;

	// reset synchroniser
	logic                          rst_meta_n;
	logic                          rst_sync_n;
	// clip detection and live event summaries
	logic [CHANNELS-1:0][7:0]      clip_cnt;
	logic [CHANNELS-1:0]           clip_hit;
	logic                          clip_now;
	logic                          otw_now;
	logic                          ilim_now;
	// pin gating, protection and sticky status
	logic                          fault_pin_now;
	logic                          warn_pin_now;
	logic                          hard_fault;
	logic                          por_pending;
	logic [31:0]                   ramp_cnt;
	fwp_status_type                next_status;

	// reset released through two flops so deassertion is clean
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// per-channel run length of full modulation in pwm clocks
	// saturates at the top so a long clip never wraps back below the window
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			clip_cnt <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (!warn_in.chan_full_mod[i]) begin
					clip_cnt[i] <= 8'h00;
				end else if (pwm_tick && clip_cnt[i] != 8'hFF) begin
					clip_cnt[i] <= clip_cnt[i] + 8'h01; // [RL8]
				end
			end
		end
	end

	// window of zero behaves as one clock so the flag cannot fire without modulation
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			clip_hit[i] = warn_in.chan_full_mod[i] && (clip_cnt[i] >= clip_window) && (clip_cnt[i] != 8'h00); // [RL8]
		end
	end

	// live summaries; clip and overtemp each feed both the status bits and the caution pin, ilim_now only the pin
	assign clip_now = clip_latching ? |clip_hit : |warn_in.chan_full_mod; // [RL19]
	assign otw_now  = warn_in.overtemp_warning | (|warn_in.chan_overtemp_warning); // [RL10]
	assign ilim_now = |warn_in.current_limit_warning; // [RL20]

	// sticky status: set wins over the release, so a live source reappears next cycle
	always_comb begin
		next_status = clear_latch_wr ? '0 : status; // [RL21]
		// fault group
		next_status.chan_fault        = next_status.chan_fault | fault_in.chan_fault; // [RL4] [RL22]
		next_status.overtemp_shutdown = next_status.overtemp_shutdown | fault_in.overtemp_shutdown;
		next_status.supply_high_alarm = next_status.supply_high_alarm | fault_in.supply_high_alarm; // [RL1]
		next_status.supply_low_alarm  = next_status.supply_low_alarm | fault_in.supply_low_alarm;
		next_status.clock_error       = next_status.clock_error | fault_in.clock_error;
		// warning group
		next_status.overtemp_warning  = next_status.overtemp_warning | otw_now;
		next_status.current_limit_warning = next_status.current_limit_warning | warn_in.current_limit_warning;
		next_status.por               = next_status.por | por_pending; // [RL18]
		// non-latching clip mirrors the live condition only
		next_status.clip = clip_latching ? (next_status.clip | clip_now) : clip_now; // [RL9] [RL19]
	end

	// status register; apart from non-latching clip, cleared only by reset or the release write
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// protective action follows the recorded faults, so masking the pin cannot keep play alive
	assign hard_fault = |{status.chan_fault, status.overtemp_shutdown, status.supply_high_alarm,
	                      status.supply_low_alarm, status.clock_error}; // [RL5]

	// por event is reported once after every reset release
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			por_pending <= 1'b1;
		end else begin
			por_pending <= 1'b0; // [RL18]
		end
	end

	// masks only gate the pins; reset values of masks are the host's cleared fields
	assign fault_pin_now = (!fault_mask.chan    && |fault_in.chan_fault)
	                     | (!fault_mask.thermal && fault_in.overtemp_shutdown)
	                     | (!fault_mask.supply  && (fault_in.supply_high_alarm | fault_in.supply_low_alarm))
	                     | (!fault_mask.clock   && fault_in.clock_error); // [RL2] [RL5] [RL6]
	// caution gating; the power-on event is never masked
	assign warn_pin_now  = (!warn_mask.clip && clip_now)
	                     | (!warn_mask.overtemp && otw_now)
	                     | (!warn_mask.current_limit && ilim_now)
	                     | por_pending; // [RL7] [RL12]

	// open-drain data is low out of reset (alarm data is high during reset); only the enables move
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			alarm_out   <= 1'b1;
			caution_out <= 1'b0;
		end else begin
			alarm_out   <= 1'b0;
			caution_out <= 1'b0;
		end
	end

	// alarm latch; current limit never reaches this path, a set beats the release
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			alarm_oe_n <= 1'b1;
		end else if (fault_pin_now) begin
			alarm_oe_n <= 1'b0; // [RL1] [RL2] [RL20]
		end else if (clear_latch_wr) begin
			alarm_oe_n <= 1'b1; // [RL3] [RL21]
		end
	end

	// caution latch; power-on reset shows on caution at once
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			caution_oe_n <= 1'b0;
		end else if (warn_pin_now) begin
			caution_oe_n <= 1'b0; // [RL7] [RL22]
		end else if (clear_latch_wr) begin
			caution_oe_n <= 1'b1; // [RL13] [RL21]
		end
	end

	// release bit reads back one for a single cycle then self-clears
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			clear_latch_bit <= 1'b0;
		end else begin
			clear_latch_bit <= clear_latch_wr; // [RL21]
		end
	end

	// warning threshold field, a register the analog sensor reads
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			otw_level <= OTW_LVL_RESET;
		end else begin
			otw_level <= otw_level_sel; // [RL11]
		end
	end

	// ramp-down timer: standby waits for it before stopping the oscillator
	// the count restarts whenever standby is released, so a short standby pulse is harmless
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ramp_cnt    <= '0;
			ramp_active <= 1'b0;
		end else if (standby_n) begin
			ramp_cnt    <= '0;
			ramp_active <= 1'b0;
		end else if (!ramp_active && (op_state == ST_MUTE || op_state == ST_PLAY)) begin
			ramp_cnt    <= 32'(RAMP_CYCLES - 1);
			ramp_active <= 1'b1; // [RL15]
		end else if (ramp_active && ramp_cnt != 32'h0) begin
			ramp_cnt <= ramp_cnt - 32'h1;
		end else begin
			ramp_active <= 1'b0;
		end
	end

	// operating state; with standby high, any recorded hard fault forces outputs floating
	// whether or not that fault category is masked from the alarm pin
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			op_state <= ST_STANDBY;
		end else begin
			case (op_state)
				ST_STANDBY: begin
					if (standby_n) begin
						op_state <= ST_FLOATING;
					end
				end
				ST_FLOATING: begin
					if (!standby_n) begin
						op_state <= ST_STANDBY;
					end else if (play_request && !hard_fault) begin
						op_state <= mute_n ? ST_PLAY : ST_MUTE; // [RL14]
					end
				end
				ST_MUTE, ST_PLAY: begin
					if (!standby_n && ramp_active && ramp_cnt == 32'h0) begin
						op_state <= ST_STANDBY; // [RL15]
					end else if (standby_n && (!play_request || hard_fault)) begin
						op_state <= ST_FLOATING;
					end else if (standby_n) begin
						op_state <= mute_n ? ST_PLAY : ST_MUTE; // [RL14]
					end
				end
				default: begin
					op_state <= ST_STANDBY;
				end
			endcase
		end
	end

	// decoded state outputs for the power stage, one flop per concern
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			outputs_floating <= 1'b1;
		end else begin
			outputs_floating <= (op_state == ST_STANDBY) || (op_state == ST_FLOATING); // [RL16]
		end
	end

	// oscillator stops only in standby
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			osc_run <= 1'b0;
		end else begin
			osc_run <= (op_state != ST_STANDBY); // [RL16]
		end
	end

	// mute follows the pin at once instead of waiting for the state to move
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mute_all <= 1'b1;
		end else begin
			mute_all <= (op_state != ST_PLAY) || !standby_n || !mute_n; // [RL14] [RL15]
		end
	end
endmodule // fwp_top

// File: fwp_top_test.sv
// fwp_top_test: self-checking bench for the fault/warning pin logic
// assumes fwp_pkg compiled first; ramp shortened to 20 cycles
`timescale 1ns/1ps
module fwp_top_test;
	import fwp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	fwp_fault_type fault_in = '0;
	fwp_warn_type warn_in = '0;
	fwp_fault_mask_type fault_mask = '0;
	fwp_warn_mask_type warn_mask = '0;
	fwp_status_type status;
	fwp_state_type op_state;
	logic [7:0] clip_window = CLIP_WIN_RESET;
	logic [1:0] otw_level_sel = OTW_LVL_RESET;
	logic [1:0] otw_level;
	logic pwm_tick = 1'b0, clip_latching = 1'b1, clear_latch_wr = 1'b0, want_play = 1'b0, want_off = 1'b1;
	logic want_mute = 1'b0;
	logic mute_n, standby_n, play_request, power_good, alarm_out, alarm_oe_n, caution_out, caution_oe_n;
	logic clear_latch_bit, outputs_floating, osc_run, mute_all, ramp_active;
	logic [31:0] seed = 32'h0000_1921;
	logic [31:0] r;
	int errors = 0, num_checks = 0, idx;

	fwp_top #(.RAMP_CYCLES(20)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .fault_in(fault_in), .warn_in(warn_in),
		.pwm_tick(pwm_tick), .fault_mask(fault_mask), .warn_mask(warn_mask), .clip_window(clip_window),
		.clip_latching(clip_latching), .otw_level_sel(otw_level_sel), .clear_latch_wr(clear_latch_wr),
		.play_request(play_request), .mute_n(mute_n), .standby_n(standby_n), .alarm_out(alarm_out),
		.alarm_oe_n(alarm_oe_n), .caution_out(caution_out), .caution_oe_n(caution_oe_n), .status(status),
		.otw_level(otw_level), .clear_latch_bit(clear_latch_bit), .op_state(op_state),
		.outputs_floating(outputs_floating), .osc_run(osc_run), .mute_all(mute_all), .ramp_active(ramp_active));
	fwp_host host (.clk_sys(clk_sys), .want_play(want_play), .want_off(want_off), .want_mute(want_mute),
		.mute_n(mute_n), .standby_n(standby_n), .play_request(play_request), .power_good(power_good));
	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// whether fault bit i reaches the alarm pin under mask m
	function automatic logic reach(int i, fwp_fault_mask_type m);
		return i > 3 ? !m.chan : i == 3 ? !m.thermal : i == 0 ? !m.clock : !m.supply;
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic clear();
		clear_latch_wr = 1'b1;
		step(1);
		clear_latch_wr = 1'b0;
		chk(clear_latch_bit, 1);
		step(1);
		chk(clear_latch_bit, 0);
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#40000;
		errors++;
		finish_test();
	end

	initial begin
		for (int p = 0; p < 2; p++) begin
			rst_n = 1'b0;
			step(4);
			rst_n = 1'b1;
			step(4);
			chk(status.por, 1);
			chk(caution_oe_n, 0);
			chk(alarm_oe_n, 1);
			chk(alarm_out, 0);
			chk(caution_out, 0);
			clear();
			chk(caution_oe_n, 1);
		end
		// every fault source, then random masks
		for (int k = 0; k < 24; k++) begin
			r = rnd();
			idx = k < 8 ? k : int'(r[6:4]);
			fault_mask = k < 8 ? '0 : fwp_fault_mask_type'(r[3:0]);
			fault_in = fwp_fault_type'(8'h01 << idx);
			step(1);
			fault_in = '0;
			step(2);
			chk(status[idx + 7], 1);
			chk(alarm_oe_n, !reach(idx, fault_mask));
			clear();
			chk(status[idx + 7], 0);
			chk(alarm_oe_n, 1);
		end
		fault_mask = '0;
		// release while the source is still present
		fault_in.clock_error = 1'b1;
		step(1);
		clear();
		chk(status.clock_error, 1);
		chk(alarm_oe_n, 0);
		fault_in = '0;
		clear();
		// warnings with random masks
		for (int k = 0; k < 9; k++) begin
			r = rnd();
			warn_mask = fwp_warn_mask_type'(r[2:0]);
			case (k % 3)
				0: warn_in.overtemp_warning = 1'b1;
				1: warn_in.chan_overtemp_warning[r[5:4]] = 1'b1;
				default: warn_in.current_limit_warning[r[5:4]] = 1'b1;
			endcase
			step(1);
			warn_in = '0;
			step(2);
			chk(caution_oe_n, k % 3 == 2 ? r[0] : r[1]);
			chk(status.overtemp_warning, k % 3 != 2);
			chk(|status.current_limit_warning, k % 3 == 2);
			chk(alarm_oe_n, 1);
			clear();
		end
		warn_mask = '0;
		otw_level_sel = 2'h3;
		step(2);
		chk(otw_level, 2'h3);
		// clip after a random window of ticks
		r = rnd();
		clip_window = 8'h03 + r[2:0];
		warn_in.chan_full_mod[r[5:4]] = 1'b1;
		for (int t = 1; t <= clip_window + 1; t++) begin
			pwm_tick = 1'b1;
			step(1);
			pwm_tick = 1'b0;
			step(1);
			if (t == clip_window - 1) chk(status.clip, 0);
		end
		warn_in = '0;
		step(2);
		chk(status.clip, 1);
		chk(caution_oe_n, 0);
		clear();
		// non-latching clip follows the live condition
		clip_latching = 1'b0;
		warn_in.chan_full_mod[0] = 1'b1;
		step(1);
		chk(status.clip, 1);
		warn_in = '0;
		step(1);
		chk(status.clip, 0);
		chk(caution_oe_n, 0);
		clear();
		chk(caution_oe_n, 1);
		clip_latching = 1'b1;
		// play, mute, then standby with ramp
		want_off = 1'b0;
		want_play = 1'b1;
		for (int w = 0; w < 50 && op_state !== ST_PLAY; w++) step(1);
		chk(op_state, ST_PLAY);
		step(1);
		chk(mute_all, 0);
		chk(outputs_floating, 0);
		chk(osc_run, 1);
		want_mute = 1'b1;
		step(3);
		chk(op_state, ST_MUTE);
		chk(mute_all, 1);
		want_mute = 1'b0;
		step(3);
		chk(mute_all, 0);
		want_off = 1'b1;
		step(3);
		chk(ramp_active, 1);
		chk(mute_all, 1);
		step(15);
		chk(op_state, ST_PLAY);
		chk(power_good, 1'b1);
		step(20);
		chk(op_state, ST_STANDBY);
		chk(outputs_floating, 1);
		chk(osc_run, 0);
		chk(ramp_active, 0);
		chk(power_good, 1'b0);
		finish_test();
	end
endmodule // fwp_top_test

bind fwp_top fwp_checker #(.CHANNELS(CHANNELS), .RAMP_CYCLES(RAMP_CYCLES)) chk_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .fault_in(fault_in), .warn_in(warn_in), .fault_mask(fault_mask),
	.warn_mask(warn_mask), .clear_latch_wr(clear_latch_wr), .mute_n(mute_n), .standby_n(standby_n),
	.alarm_oe_n(alarm_oe_n), .caution_oe_n(caution_oe_n), .status(status), .clear_latch_bit(clear_latch_bit),
	.op_state(op_state), .outputs_floating(outputs_floating), .osc_run(osc_run), .mute_all(mute_all),
	.ramp_active(ramp_active));
